// *** common/nfc_pkg.sv ***
package nfc_pkg;
  // ----------------------------------------
  // Clock and flash bus timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS      = 60;
  localparam int GAP_NS        = 30;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWR_WAIT_MS   = 10;
  localparam int PWR_WAIT_CYC  = PWR_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ADDR_W        = 21;
  localparam int DATA_W        = 16;
  localparam int CNT_W         = 8;
  localparam int PWR_CNT_W     = 24;

  // ----------------------------------------
  // Command words
  // ----------------------------------------
  localparam logic [15:0] CMD_READ_ARRAY  = 16'h00FF;
  localparam logic [15:0] CMD_CFI_QUERY   = 16'h0098;
  localparam logic [15:0] CMD_PROG_SETUP  = 16'h0040;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
  localparam logic [15:0] CMD_CONFIRM     = 16'h00D0;
  localparam logic [15:0] CMD_SUSPEND     = 16'h00B0;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STAT  = 16'h0050;

  // ----------------------------------------
  // Device operation_status bits
  // ----------------------------------------
  localparam int SR_MACHINE_READY   = 7;
  localparam int SR_ERASE_SUSPENDED = 6;
  localparam int SR_ERASE_FAIL      = 5;
  localparam int SR_PROGRAM_FAIL    = 4;
  localparam int SR_SUPPLY_FAULT    = 3;
  localparam int SR_PROG_SUSPENDED  = 2;
  localparam int SR_LOCK_ABORT      = 1;
  localparam logic [7:0] SR_ERR_MASK = 8'h3A;
  localparam logic [7:0] SR_RESET    = 8'h80;

  // ----------------------------------------
  // Controller registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int ST_BUSY    = 8;
  localparam int ST_REFUSED = 9;
  localparam int ST_PWR_OK  = 10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_RESUME,
    OP_CLEAR, OP_CFI_QUERY, OP_READ_WORD, OP_READ_STATUS
  } nfc_op_e;
  localparam logic [3:0] OP_LAST = 4'h8;
endpackage : nfc_pkg

// *** common/nfc_cyc_if.sv ***
`timescale 1ns/1ps
interface nfc_cyc_if;
  logic        req;
  logic        wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport slave  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : nfc_cyc_if

// *** hw/nfc_cycle.sv ***
`timescale 1ns/1ps
module nfc_cycle
  import nfc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  nfc_cyc_if.slave         cyc,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [20:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_GAP} nfc_cst_e;
  typedef struct packed {
    nfc_cst_e          st;
    logic [CNT_W-1:0]  cnt;
    logic              wr;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe;
    logic [20:0]       addr;
    logic [15:0]       dq_out;
    logic [15:0]       s1;
    logic [15:0]       s2;
    logic [15:0]       s3;
    logic              done;
    logic [15:0]       rdata;
  } nfc_cyc_s;

  nfc_cyc_s r_reg, r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    r_next.s1   = flash_dq_in;
    r_next.s2   = r_reg.s1;
    r_next.s3   = r_reg.s2;
    unique case (r_reg.st)
      C_IDLE: begin
        if (cyc.req && !r_reg.done) begin
          r_next.wr     = cyc.wr;
          r_next.addr   = cyc.addr;
          r_next.dq_out = cyc.wdata;
          r_next.dq_oe  = cyc.wr;
          r_next.ce_n   = 1'b0;
          r_next.cnt    = CNT_W'(GAP_CYC);
          r_next.st     = C_SETUP;
        end
      end
      C_SETUP: begin
        if (r_reg.cnt > CNT_W'(1)) begin
          r_next.cnt = r_reg.cnt - CNT_W'(1);
        end else begin
          // Strobe low only with the opposite strobe high
          r_next.we_n = !r_reg.wr;
          r_next.oe_n = r_reg.wr;
          r_next.cnt  = CNT_W'(PULSE_CYC);
          r_next.st   = C_PULSE;
        end
      end
      C_PULSE: begin
        if (r_reg.cnt > CNT_W'(1)) begin
          r_next.cnt = r_reg.cnt - CNT_W'(1);
        end else if (r_reg.wr || r_reg.s2 == r_reg.s3) begin
          r_next.we_n = 1'b1;
          r_next.oe_n = 1'b1;
          r_next.ce_n = 1'b1;
          if (!r_reg.wr) begin
            r_next.rdata = r_reg.s3;
          end
          r_next.cnt = CNT_W'(GAP_CYC);
          r_next.st  = C_GAP;
        end
      end
      C_GAP: begin
        // Data held past the strobe edge for hold time
        if (r_reg.cnt > CNT_W'(1)) begin
          r_next.cnt = r_reg.cnt - CNT_W'(1);
        end else begin
          r_next.dq_oe = 1'b0;
          r_next.done  = 1'b1;
          r_next.st    = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg      <= '0;
      r_reg.st   <= C_IDLE;
      r_reg.ce_n <= 1'b1;
      r_reg.oe_n <= 1'b1;
      r_reg.we_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cyc.done     = r_reg.done;
  assign cyc.rdata    = r_reg.rdata;
  assign flash_ce_n   = r_reg.ce_n;
  assign flash_oe_n   = r_reg.oe_n;
  assign flash_we_n   = r_reg.we_n;
  assign flash_addr   = r_reg.addr;
  assign flash_dq_out = r_reg.dq_out;
  assign flash_dq_oe  = r_reg.dq_oe;
endmodule : nfc_cycle

// *** hw/nfc_host.sv ***
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// How it works
// - Query mode entered by one write of code 98 to any address.
// - Word program: code 40 anywhere, then data word at target.
// - Status reads need a fresh chip-select or output-drive toggle each.
// - Code FF after last operation returns device to array read.
// - Suspend with B0, resume with D0; bit 2 shows program suspended.
// - Sector erase: code 20 anywhere, then D0 inside target sector.
// - During erase suspend, read or program only other sectors; the controller sends reads and programs to any address.
// - Clear-status is one write of 50; clears error bits.
module nfc_host
  import nfc_pkg::*;
#(
  parameter int PWR_WAIT = PWR_WAIT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             flash_rst_n,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [20:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {Q_IDLE, Q_CMD, Q_DATA, Q_POLL, Q_READ} nfc_seq_e;
  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 aw_got;
    logic                 w_got;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    nfc_seq_e             sq;
    nfc_op_e              op;
    logic [20:0]          addr;
    logic [15:0]          wword;
    logic [15:0]          rword;
    logic [7:0]           sr;
    logic                 refused;
    logic                 pwr_ok;
    logic [PWR_CNT_W-1:0] pwr_cnt;
    logic                 rst_out_n;
    logic                 req;
    logic                 cwr;
    logic [15:0]          cword;
  } nfc_host_s;

  nfc_host_s r_reg, r_next;
  nfc_cyc_if cyc ();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction : merge

  function automatic logic [15:0] first_code(input nfc_op_e op);
    unique case (op)
      OP_PROGRAM:     return CMD_PROG_SETUP;
      OP_ERASE:       return CMD_ERASE_SETUP;
      OP_SUSPEND:     return CMD_SUSPEND;
      OP_RESUME:      return CMD_CONFIRM;
      OP_CLEAR:       return CMD_CLEAR_STAT;
      OP_CFI_QUERY:   return CMD_CFI_QUERY;
      OP_READ_STATUS: return CMD_READ_STATUS;
      default:        return CMD_READ_ARRAY;
    endcase
  endfunction : first_code

  always_comb begin
    logic [31:0] wv;
    logic        refuse;
    wv     = '0;
    refuse = 1'b0;
    r_next = r_reg;
    // ----------------------------------------
    // Supply settle wait
    // ----------------------------------------
    r_next.rst_out_n = 1'b1;
    if (!r_reg.pwr_ok) begin
      if (r_reg.pwr_cnt >= PWR_CNT_W'(PWR_WAIT - 1)) begin
        r_next.pwr_ok = 1'b1;
      end else begin
        r_next.pwr_cnt = r_reg.pwr_cnt + PWR_CNT_W'(1);
      end
    end
    // ----------------------------------------
    // AXI write
    // ----------------------------------------
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got  = 1'b1;
      r_next.awaddr  = s_axi_awaddr;
      r_next.awready = 1'b0;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got  = 1'b1;
      r_next.wdata  = s_axi_wdata;
      r_next.wstrb  = s_axi_wstrb;
      r_next.wready = 1'b0;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid  = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready  = 1'b1;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = RESP_OKAY;
      unique case (r_reg.awaddr)
        REG_ADDR:  begin
          wv            = merge({11'h000, r_reg.addr}, r_reg.wdata, r_reg.wstrb);
          r_next.addr   = wv[20:0];
        end
        REG_WDATA: begin
          wv            = merge({16'h0000, r_reg.wword}, r_reg.wdata, r_reg.wstrb);
          r_next.wword  = wv[15:0];
        end
        REG_CTRL: begin
          // A start while busy is dropped and flagged, not queued
          if (r_reg.wstrb[0]) begin
            if (r_reg.sq != Q_IDLE || r_reg.wdata[3:0] > OP_LAST) begin
              refuse = 1'b1;
            end else begin
              r_next.op = nfc_op_e'(r_reg.wdata[3:0]);
              unique case (nfc_op_e'(r_reg.wdata[3:0]))
                OP_PROGRAM: refuse = !r_reg.pwr_ok || r_reg.sr[SR_SUPPLY_FAULT];
                OP_ERASE:   refuse = !r_reg.pwr_ok || r_reg.sr[SR_SUPPLY_FAULT]
                                     || r_reg.sr[SR_LOCK_ABORT];
                default:    refuse = 1'b0;
              endcase
            end
            r_next.refused = refuse;
            if (!refuse) begin
              r_next.cwr   = 1'b1;
              r_next.cword = first_code(nfc_op_e'(r_reg.wdata[3:0]));
              r_next.req   = 1'b1;
              r_next.sq    = Q_CMD;
              if (nfc_op_e'(r_reg.wdata[3:0]) == OP_READ_WORD) begin
                r_next.cwr = 1'b0;
                r_next.sq  = Q_READ;
              end
            end
          end
        end
        REG_STATUS, REG_RDATA: ;
        default: r_next.bresp = RESP_DECERR;
      endcase
    end
    // ----------------------------------------
    // AXI read
    // ----------------------------------------
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.arready = 1'b0;
      r_next.rvalid  = 1'b1;
      r_next.rresp   = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL:   r_next.rdata = {28'h0000000, r_reg.op};
        REG_ADDR:   r_next.rdata = {11'h000, r_reg.addr};
        REG_WDATA:  r_next.rdata = {16'h0000, r_reg.wword};
        REG_STATUS: r_next.rdata = {21'h000000, r_reg.pwr_ok, r_reg.refused, r_reg.sq != Q_IDLE, r_reg.sr};
        REG_RDATA:  r_next.rdata = {16'h0000, r_reg.rword};
        default: begin
          r_next.rdata = '0;
          r_next.rresp = RESP_DECERR;
        end
      endcase
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid  = 1'b0;
      r_next.arready = 1'b1;
    end
    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    if (cyc.done) begin
      r_next.req = 1'b0;
      unique case (r_reg.sq)
        Q_CMD: begin
          unique case (r_reg.op)
            OP_PROGRAM: begin
              r_next.cword = r_reg.wword;
              r_next.req   = 1'b1;
              r_next.sq    = Q_DATA;
            end
            OP_ERASE: begin
              r_next.cword = CMD_CONFIRM;
              r_next.req   = 1'b1;
              r_next.sq    = Q_DATA;
            end
            OP_SUSPEND, OP_RESUME, OP_READ_STATUS: begin
              r_next.cwr = 1'b0;
              r_next.req = 1'b1;
              r_next.sq  = Q_POLL;
            end
            OP_CLEAR: begin
              r_next.sr = r_reg.sr & ~SR_ERR_MASK;
              r_next.sq = Q_IDLE;
            end
            default: r_next.sq = Q_IDLE;
          endcase
        end
        Q_DATA: begin
          r_next.cwr = 1'b0;
          r_next.req = 1'b1;
          r_next.sq  = Q_POLL;
        end
        Q_POLL: begin
          // Each poll is a separate strobe cycle so the status refreshes
          r_next.sr = cyc.rdata[7:0];
          if (cyc.rdata[SR_MACHINE_READY] || r_reg.op == OP_READ_STATUS) begin
            r_next.sq = Q_IDLE;
          end else begin
            r_next.req = 1'b1;
          end
        end
        Q_READ: begin
          r_next.rword = cyc.rdata;
          r_next.sq    = Q_IDLE;
        end
        default: r_next.sq = Q_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg         <= '0;
      r_reg.awready <= 1'b1;
      r_reg.wready  <= 1'b1;
      r_reg.arready <= 1'b1;
      r_reg.sq      <= Q_IDLE;
      r_reg.op      <= OP_READ_ARRAY;
      r_reg.sr      <= SR_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cyc.req   = r_reg.req;
  assign cyc.wr    = r_reg.cwr;
  assign cyc.addr  = r_reg.addr;
  assign cyc.wdata = r_reg.cword;

  nfc_cycle u_cycle (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .cyc          (cyc.slave),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in)
  );

  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready  = r_reg.wready;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rresp   = r_reg.rresp;
  assign s_axi_rdata   = r_reg.rdata;
  assign flash_rst_n   = r_reg.rst_out_n;
endmodule : nfc_host

// *** dv/nfc_host_properties.sv ***
`timescale 1ns/1ps
module nfc_host_properties
  import nfc_pkg::*;
#(
  parameter int PWR_WAIT = PWR_WAIT_CYC
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        flash_rst_n,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_dq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------
  // Flash strobes
  // ------
  chk_we_inhibit: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe low while deselected or output enabled");
  chk_we_pulse: assert property ($fell(flash_we_n) |-> !flash_we_n [*6] ##1 flash_we_n)
    else $error("write strobe pulse not six cycles");
  chk_write_drives: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data not driven during write strobe");
  // Contention guard, host and flash never drive together
  chk_read_release: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data while flash outputs on");
  chk_rst_pin: assert property (aresetn && $past(aresetn) |-> flash_rst_n)
    else $error("flash reset pin still low after release");
  // ------
  // Register bus
  // ------
  chk_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                 |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after take");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not valid one cycle after take");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_we: cover property ($fell(flash_we_n));
  cov_oe: cover property ($fell(flash_oe_n));
endmodule : nfc_host_properties

bind nfc_host nfc_host_properties #(.PWR_WAIT(PWR_WAIT)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .flash_rst_n(flash_rst_n), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_oe(flash_dq_oe));

// *** dv/nfc_flash_model.sv ***
`timescale 1ns/1ps
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int         POR_NS    = 150,
  parameter logic [7:0] FAIL_AD   = 8'h30,
  parameter logic [7:0] LOCK_AD   = 8'h40,
  parameter logic [7:0] EFAIL_AD  = 8'h50
) (
  input  wire logic        rst_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  input  wire logic        supply_ok,
  output logic      [15:0] dq_in
);
  logic [15:0] mem [256];
  logic [7:0]  op_status;
  logic [1:0]  mode;
  logic [1:0]  pend;
  logic        erasing, susp;
  logic [15:0] shown;
  int          left;
  time         por_t;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
    {mode, pend, susp, erasing, left, por_t, shown} = '0;
    op_status = SR_RESET;
  end
  always @(negedge rst_n) begin
    {mode, pend, susp, left} = '0;
    op_status = SR_RESET;
  end
  always @(posedge rst_n) por_t = $time;
  // ------
  // Busy timing, ticks of 100 ns
  // ------
  always #100 begin
    if (left > 0 && !susp) begin
      left = left - 1;
      if (left == 0) op_status[7] = 1'b1;
    end
  end
  // Latched at the falling write strobe; address and data are settled by then
  always @(negedge we_n) begin
    if (!ce_n && oe_n && rst_n) begin
      if (pend == 2'd1) begin
        pend = 2'd0;
        mode = 2'd1;
        if (!supply_ok) op_status[3] = 1'b1;
        else if (!op_status[3] && $time >= por_t + POR_NS) begin
          if (addr[7:0] == LOCK_AD) op_status[1] = 1'b1;
          else begin
            mem[addr[7:0]] = mem[addr[7:0]] & dq_out;
            if (addr[7:0] == FAIL_AD) op_status[4] = 1'b1;
            op_status[7] = 1'b0;
            left = 20;
            erasing = 1'b0;
          end
        end
      end else if (pend == 2'd2) begin
        pend = 2'd0;
        mode = 2'd1;
        if (dq_out[7:0] != 8'hD0) op_status[5:4] = 2'b11;
        else if (!supply_ok) op_status[3] = 1'b1;
        else if (!op_status[1] && !op_status[3]) begin
          for (int i = 0; i < 16; i++) mem[{addr[7:4], i[3:0]}] = 16'hFFFF;
          if (addr[7:0] == EFAIL_AD) op_status[5] = 1'b1;
          op_status[7] = 1'b0;
          left = 40;
          erasing = 1'b1;
        end
      end else begin
        case (dq_out[7:0])
          8'hFF: mode = 2'd0;
          8'h98: mode = 2'd2;
          8'h40: pend = 2'd1;
          8'h20: pend = 2'd2;
          8'h50: op_status = op_status & ~SR_ERR_MASK;
          8'h70: mode = 2'd1;
          8'hB0: begin
            mode = 2'd1;
            if (left > 0) begin
              susp = 1'b1;
              op_status[7] = 1'b1;
              op_status[erasing ? 6 : 2] = 1'b1;
            end
          end
          8'hD0: begin
            mode = 2'd1;
            if (susp) op_status[7:6] = 2'b00;
            op_status[2] = 1'b0;
            susp = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
  // Value refreshed only by a fresh select or output strobe
  always @(negedge ce_n or negedge oe_n) begin
    if (!ce_n && !oe_n)
      shown = (mode == 2'd1) ? {8'h00, op_status} : (mode == 2'd2) ? {8'hC0, addr[7:0]}
            : mem[addr[7:0]];
  end
  // Released bus shows the inverse of the last value, not a held copy
  assign dq_in = dq_oe ? dq_out : (!ce_n && !oe_n) ? shown : ~shown;
endmodule : nfc_flash_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import nfc_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, supply_ok = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rst_n, ce_n, oe_n, we_n, dq_oe;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, st, rd;
  logic [20:0] faddr;
  logic [15:0] dq_out, dq_in;
  int          error_cnt = 0, comparisons = 0;
  always #5 aclk = ~aclk;
  nfc_host #(.PWR_WAIT(20)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_rst_n(rst_n),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  nfc_flash_model u_flash (
    .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr), .dq_out(dq_out),
    .dq_oe(dq_oe), .supply_ok(supply_ok), .dq_in(dq_in));
  // ------
  // Bus and compare tasks
  // ------
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_word(what, {30'h0, exp}, {30'h0, got});
  endtask : check_resp
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic poll_idle();
    st = 32'h100;
    while (st[ST_BUSY] !== 1'b0) axi_rd(REG_STATUS, st, resp);
  endtask : poll_idle
  task automatic run_op(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d,
                        input logic [31:0] exp);
    axi_wr(REG_ADDR, {11'h0, a}, resp);
    axi_wr(REG_WDATA, {16'h0, d}, resp);
    axi_wr(REG_CTRL, {28'h0, op}, resp);
    poll_idle();
    check_word("status", exp, st);
  endtask : run_op
  task automatic rd_word(input logic [20:0] a, input logic [15:0] exp);
    run_op(4'h7, a, 16'h0, 32'h480);
    axi_rd(REG_RDATA, rd, resp);
    check_word("rdata", {16'h0, exp}, rd);
  endtask : rd_word
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ------
  // Tests
  // ------
  initial begin
    #500us;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_STATUS, st, resp);
    check_word("status reset", 32'h080, st);
    check_word("flash reset pin", 32'h1, {31'h0, rst_n});
    run_op(4'h1, 21'h5, 16'h1234, 32'h280);
    axi_rd(8'h20, rd, resp);
    check_resp("unmapped read", RESP_DECERR, resp);
    check_word("unmapped data", 32'h0, rd);
    axi_wr(8'h24, 32'h1, resp);
    check_resp("unmapped write", RESP_DECERR, resp);
    while (st[ST_PWR_OK] !== 1'b1) axi_rd(REG_STATUS, st, resp);
    $display("test reset done");
    run_op(4'h1, 21'h5, 16'h1234, 32'h480);
    run_op(4'h0, 21'h0, 16'h0, 32'h480);
    rd_word(21'h5, 16'h1234);
    run_op(4'h6, 21'h0, 16'h0, 32'h480);
    rd_word(21'h10, 16'hC010);
    run_op(4'h0, 21'h0, 16'h0, 32'h480);
    rd_word(21'h5, 16'h1234);
    run_op(4'h9, 21'h6, 16'h0, 32'h680);
    axi_wr(REG_CTRL, 32'h1, resp);
    axi_wr(REG_CTRL, 32'h1, resp);
    poll_idle();
    check_word("status back to back", 32'h680, st);
    $display("test program done");
    run_op(4'h1, 21'h30, 16'h0, 32'h490);
    run_op(4'h0, 21'h0, 16'h0, 32'h490);
    run_op(4'h8, 21'h0, 16'h0, 32'h490);
    run_op(4'h5, 21'h0, 16'h0, 32'h480);
    run_op(4'h1, 21'h40, 16'h0, 32'h482);
    run_op(4'h2, 21'h40, 16'h0, 32'h682);
    run_op(4'h5, 21'h0, 16'h0, 32'h480);
    run_op(4'h0, 21'h0, 16'h0, 32'h480);
    rd_word(21'h40, 16'hFFFF);
    supply_ok = 1'b0;
    run_op(4'h1, 21'h6, 16'h0, 32'h488);
    run_op(4'h1, 21'h6, 16'h0, 32'h688);
    run_op(4'h2, 21'h20, 16'h0, 32'h688);
    supply_ok = 1'b1;
    run_op(4'h5, 21'h0, 16'h0, 32'h480);
    $display("test errors done");
    run_op(4'h2, 21'h20, 16'h0, 32'h480);
    run_op(4'h2, 21'h50, 16'h0, 32'h4A0);
    run_op(4'h5, 21'h0, 16'h0, 32'h480);
    run_op(4'h3, 21'h0, 16'h0, 32'h480);
    run_op(4'h4, 21'h0, 16'h0, 32'h480);
    $display("test erase and suspend done");
    print_verdict();
  end
endmodule : tb_top
